// ==== rtl/tap_pin_port.sv ====
// Test access port controller with dedicated and shared pin selection
`timescale 1ns/1ps
// Operation
// - Select high disconnects the dedicated test pins from the controller.
// - Select high: irq line seven is TMS, irq line six is TRST.
// - Select high: serial receive is TDI, serial transmit is TDO.
// - Select high: test clock comes from keypad row seven.
// - TMS is sampled on each rising test clock edge to advance state.
// - TDI is captured on each rising test clock edge in shift-IR or shift-DR.
// - TDO is driven only in shift-IR or shift-DR, else released.
// - Low test reset forces Test-Logic-Reset at once, without a clock.
module tap_pin_port
  import tap_pkg::*;
(
  // Core clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  // Pin selection, quasi-static strap
  input  wire logic                debug_pin_select_i,
  // Dedicated test pins
  input  wire logic                tck_i,
  input  wire logic                tms_i,
  input  wire logic                tdi_i,
  input  wire logic                trst_n_i,
  output logic                     tdo_o,
  output logic                     tdo_oe_o,
  // Shared alternate pins
  input  wire logic                keypad_row_seven_i,
  input  wire logic                irq_line_seven_i,
  input  wire logic                irq_line_six_i,
  input  wire logic                serial_rx_i,
  output logic                     serial_tx_o,
  output logic                     serial_tx_oe_o,
  // Serial transmit from the normal function when not in debug use
  input  wire logic                uart_tx_i,
  // Status in the core domain
  output logic                     tap_in_reset_o,
  output logic [IR_WIDTH-1:0]      tap_instr_o
);

  tap_pins_type   pins;
  logic           tap_clk;
  logic           tap_rst_n;
  tap_state_type  state;
  tap_state_type  next_state;
  logic [IR_WIDTH-1:0] ir_shift;
  logic [IR_WIDTH-1:0] next_ir_shift;
  logic [IR_WIDTH-1:0] ir;
  logic [IR_WIDTH-1:0] next_ir;
  logic           bypass;
  logic           next_bypass;
  logic           tdo_bit;
  logic           tdo_en;
  logic           shift_out;
  tap_status_type status;
  tap_status_type sync1;
  tap_status_type sync2;
  tap_status_type held;
  tap_status_type next_held;

  // Pin mux; the clock mux assumes the select only moves while idle
  always_comb begin
    if (debug_pin_select_i) begin
      pins.tms    = irq_line_seven_i;
      pins.trst_n = irq_line_six_i;
      pins.tdi    = serial_rx_i;
      tap_clk     = keypad_row_seven_i;
    end else begin
      pins.tms    = tms_i;
      pins.trst_n = trst_n_i;
      pins.tdi    = tdi_i;
      tap_clk     = tck_i;
    end
  end

  // Power-on reset also clears the controller; both are asynchronous
  assign tap_rst_n = pins.trst_n & rst_n_i;

  // Next-state sequence of the sixteen-state controller
  always_comb begin
    unique case (state)
      ST_RESET:    next_state = pins.tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     next_state = pins.tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   next_state = pins.tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   next_state = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = pins.tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = pins.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = pins.tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   next_state = pins.tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   next_state = pins.tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   next_state = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = pins.tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = pins.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = pins.tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   next_state = pins.tms ? ST_SEL_DR   : ST_IDLE;
    endcase
  end

  // Instruction and bypass shift paths
  always_comb begin
    next_ir_shift = ir_shift;
    next_ir       = ir;
    next_bypass   = bypass;
    unique case (state)
      ST_RESET:    next_ir = IR_RESET;
      ST_CAP_IR:   next_ir_shift = IR_CAPTURE;
      ST_SHIFT_IR: next_ir_shift = {pins.tdi, ir_shift[IR_WIDTH-1:1]};
      ST_UPD_IR:   next_ir = ir_shift;
      ST_CAP_DR:   next_bypass = 1'b0;
      ST_SHIFT_DR: next_bypass = pins.tdi;
      default:     next_ir = ir;
    endcase
    // The clock may stop in reset, so the reset code loads on entry
    if (next_state == ST_RESET) begin
      next_ir = IR_RESET;
    end
  end

  always_ff @(posedge tap_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state    <= ST_RESET;
      ir_shift <= '0;
      ir       <= IR_RESET;
      bypass   <= 1'b0;
    end else begin
      state    <= next_state;
      ir_shift <= next_ir_shift;
      ir       <= next_ir;
      bypass   <= next_bypass;
    end
  end

  // Every data instruction selects the one-bit bypass path
  assign shift_out = (state == ST_SHIFT_IR) ? ir_shift[0] : bypass;

  // Output stage on the falling edge so the far end samples on the rise
  always_ff @(negedge tap_clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_bit <= 1'b0;
      tdo_en  <= 1'b0;
    end else begin
      tdo_bit <= shift_out;
      tdo_en  <= (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
    end
  end

  // Dedicated TDO is released entirely while the shared set is in use
  assign tdo_o          = tdo_bit;
  assign tdo_oe_o       = tdo_en & ~debug_pin_select_i;
  assign serial_tx_o    = debug_pin_select_i ? tdo_bit : uart_tx_i;
  assign serial_tx_oe_o = debug_pin_select_i ? tdo_en : 1'b1;

  // Status crosses to the core clock as quasi-static levels
  assign status.in_reset = (state == ST_RESET);
  assign status.instr    = ir;

  // A word is taken only once two samples agree, so no torn value passes
  always_comb begin
    next_held = held;
    if (sync1 == sync2) begin
      next_held = sync2;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
      held  <= '0;
    end else begin
      sync1 <= status;
      sync2 <= sync1;
      held  <= next_held;
    end
  end

  assign tap_in_reset_o = held.in_reset;
  assign tap_instr_o    = held.instr;

endmodule

// ==== common/tap_pkg.sv ====
// Shared types and constants for the test access port pin interface
package tap_pkg;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPD_IR
  } tap_state_type;

  localparam int IR_WIDTH = 4;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_WIDTH-1:0] IR_RESET = 4'hf;
  localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hf;

  // Test pins as one group, either from the dedicated or the shared set
  typedef struct packed {
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_type;

  // Status handed to the core clock domain
  typedef struct packed {
    logic                in_reset;
    logic [IR_WIDTH-1:0] instr;
  } tap_status_type;

endpackage

// ==== test/tap_pin_port_monitor.sv ====
// Port checks of the test access port pin interface
`timescale 1ns/1ps
module tap_pin_port_monitor (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic       uart_tx_i,
  input wire logic       tap_in_reset_o,
  input wire logic [3:0] tap_instr_o,
  input wire logic       debug_pin_select_i,
  input wire logic       tck_i,
  input wire logic       tms_i,
  input wire logic       trst_n_i,
  input wire logic       tdo_oe_o,
  input wire logic       keypad_row_seven_i,
  input wire logic       irq_line_seven_i,
  input wire logic       irq_line_six_i,
  input wire logic       serial_tx_o,
  input wire logic       serial_tx_oe_o
);
  wire s  = debug_pin_select_i;
  wire tk = s ? keypad_row_seven_i : tck_i;
  wire tm = s ? irq_line_seven_i : tms_i;
  wire tr = s ? irq_line_six_i : trst_n_i;
  wire oe = s ? serial_tx_oe_o : tdo_oe_o;
  chk_dedicated_off: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) s |-> !tdo_oe_o) else $error("tdo on");
  chk_uart_pass: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) !s |-> serial_tx_oe_o && serial_tx_o == uart_tx_i)
    else $error("uart path");
  chk_trst_sync: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) !tr |-> ##[1:3] tap_in_reset_o) else $error("trst");
  chk_trst_oe: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) !tr && !$past(tr) |-> !oe) else $error("trst oe");
  chk_reset_code: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) tap_in_reset_o |-> tap_instr_o == 4'hf)
    else $error("reset code");
  chk_five_ones: assert property (@(posedge tk)
    disable iff (!rst_n_i) tm [*5] |=> !oe) else $error("five ones");
  chk_shift_exit: assert property (@(posedge tk)
    disable iff (!rst_n_i) oe && tm |=> !oe) else $error("shift exit");
  chk_shift_hold: assert property (@(posedge tk)
    disable iff (!rst_n_i) oe && !tm |=> oe) else $error("shift hold");
endmodule
bind tap_pin_port tap_pin_port_monitor mon_u (.*);

// ==== test/tap_host_model.sv ====
// Test controller model; its clock runs only within a bit
`timescale 1ns/1ps
module tap_host_model (
  output logic     tck_o,
  output logic     tms_o,
  output logic     tdi_o,
  output logic     trst_n_o,
  input wire logic tdo_i
);
  initial {tck_o, tms_o, tdi_o, trst_n_o} = 4'h7;
  // Bits change while the clock is low; TDO is taken at the rise
  task automatic bit_io(input logic m, t, output logic q);
    tms_o = m;
    tdi_o = t;
    #15 tck_o = 1;
    q = tdo_i;
    #15 tck_o = 0;
  endtask
endmodule

// ==== test/tap_pin_port_bench.sv ====
// Bench for the test access port pin interface
`timescale 1ns/1ps
`define CHK(n, e, v) checks_done++; if ((v) !== (e)) begin \
  miscompares++; $display("ERROR %s exp %h got %h", n, e, v); end
module tap_pin_port_bench;
  logic       core_clk_i = 0, rst_n_i = 0, sel = 0, ux = 0;
  logic       tck, tms, tdi, tr_n, tdo, doe, tx, txe, inr;
  logic [3:0] ins;
  int         miscompares = 0, checks_done = 0, cyc = 0;
  wire        oe = sel ? txe : doe;
  wire        d = sel ? tx : tdo;
  tap_host_model host_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .trst_n_o(tr_n), .tdo_i(oe ? d : ~d));
  // Unselected set carries inverted data and a held test reset
  tap_pin_port dut_u (.core_clk_i, .rst_n_i, .debug_pin_select_i(sel),
    .tck_i(tck), .tms_i(sel ^ tms), .tdi_i(sel ^ tdi),
    .trst_n_i(!sel & tr_n), .tdo_o(tdo), .tdo_oe_o(doe),
    .keypad_row_seven_i(tck), .irq_line_seven_i(!sel ^ tms),
    .irq_line_six_i(sel & tr_n), .serial_rx_i(!sel ^ tdi),
    .serial_tx_o(tx), .serial_tx_oe_o(txe), .uart_tx_i(ux),
    .tap_in_reset_o(inr), .tap_instr_o(ins));
  initial forever #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    ux <= ~ux;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic go(input logic [7:0] m, t, input int n,
                    output logic [7:0] q);
    for (int i = 0; i < n; i++) host_u.bit_io(m[i], t[i], q[i]);
  endtask
  // Status crosses three flops, so allow four core cycles
  task automatic settle();
    repeat (4) @(negedge core_clk_i);
  endtask
  task automatic scan(input logic s);
    logic [7:0] q;
    @(posedge core_clk_i) sel <= s;
    go(8'h1f, 8'h00, 5, q);
    settle();
    `CHK("in_reset", 1'b1, inr)
    go(8'h06, 8'h00, 5, q);
    go(8'h08, 8'h0a, 4, q);
    `CHK("ir_out", 4'h1, q[3:0])
    go(8'h03, 8'h00, 4, q);
    go(8'h02, 8'h01, 2, q);
    `CHK("bypass", 2'h2, q[1:0])
    go(8'h01, 8'h00, 2, q);
    settle();
    `CHK("instr", 4'ha, ins)
  endtask
  task automatic trst_test();
    host_u.trst_n_o = 0;
    settle();
    `CHK("trst", 5'h1f, {inr, ins})
    host_u.trst_n_o = 1;
  endtask
  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1;
    scan(1'b0);
    scan(1'b1);
    trst_test();
    conclude();
  end
endmodule
